// ---- rtl/fcpi_pkg.sv ----
/*
 * constants, states and pin-group layout of the configuration pin interface.
 * assumes a single 40 MHz system clock and an active-high asynchronous reset.
 */
// What this block does
// - clock pin is input in byte and slave-serial, driven output in master-serial.
// - after configuration the clock pin is input only and its level is ignored.
// - restart input held low starts a fresh configuration sequence.
// - completion pin asserts once loading ends; driver may be open drain.
// - memory-clear pin held low while clearing, released to user afterwards.
// - byte mode: busy output paces loading; host honours it.
// - serial modes: chain output forwards each data bit; user pin afterwards.
// - byte mode: eight data pins carry the configuration bytes.
// - serial modes: one data pin carries bits; released to user afterwards.
// - byte pins become user pins after loading unless the byte port is kept.
// - each global clock pin feeds a clock buffer, else serves as user input.
// - mode-select pins choose the loading method, set before loading starts.
package fcpi_pkg;

	// ***************************************************
	// clock and timing
	// ***************************************************
	localparam int CLK_MHZ        = 40;
	localparam int CLEAR_TIME_NS  = 1000;  // memory clear duration
	localparam int MCCLK_NS       = 200;   // master clock period driven out
	localparam int STARTUP_CYCLES = 8;
	localparam int BUSY_CYCLES    = 2;     // busy time after each accepted byte
	localparam int CLEAR_CYCLES   = (CLEAR_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int MCCLK_HALF     = ((MCCLK_NS / 2) * CLK_MHZ) / 1000;

	// ***************************************************
	// mode-select encodings
	// ***************************************************
	localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
	localparam logic [2:0] MODE_SLAVE_SERIAL  = 3'h7;
	localparam logic [2:0] MODE_BYTE_PARALLEL = 3'h6;

	// ***************************************************
	// widths and reset values
	// ***************************************************
	localparam int         CNT_W      = 16;
	localparam int         SYNC_W     = 18;  // data 8, cs, write, program, mode 3, gclk 4
	localparam int         USER_PINS  = 10;  // init, busy/chain out, data 8
	localparam logic [7:0] BYTE_RESET = 8'h00;

	typedef enum logic [2:0] {
		FCPI_CLEAR,
		FCPI_MODE,
		FCPI_LOAD,
		FCPI_STARTUP,
		FCPI_USER
	} fcpi_state_t;

endpackage

// ---- rtl/fcpi_pin_if.sv ----
/*
 * synchronised pin group passed from the sampler to the loader.
 * assumes both ends run on clk_sys.
 */
interface fcpi_pin_if;
	logic       config_clock_pin_rise;
	logic [7:0] data;
	logic       cs_n;
	logic       write_n;
	logic       program_n;
	logic [2:0] mode;
	logic [3:0] gclk;

	modport src (output config_clock_pin_rise, data, cs_n, write_n, program_n, mode, gclk);
	modport dst (input config_clock_pin_rise, data, cs_n, write_n, program_n, mode, gclk);
endinterface

// ---- rtl/fcpi_pin_sync.sv ----
/*
 * two-flop synchroniser for every pin input plus clock pin edge finder.
 * assumes all pins are asynchronous to clk_sys.
 */
module fcpi_pin_sync
	import fcpi_pkg::*;
(
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              reset,
	// raw pins
	input  wire logic              config_clock_pin_in,
	input  wire logic [SYNC_W-1:0] raw,
	// synchronised group
	fcpi_pin_if.src                pins
);
	logic              c1, c2, c3;
	logic [SYNC_W-1:0] s1, s2;
	logic              next_c1, next_c2, next_c3;
	logic [SYNC_W-1:0] next_s1, next_s2;

	// first stage feeds only the second; edges are found on the second and third
	always_comb begin
		next_c1 = config_clock_pin_in;
		next_c2 = c1;
		next_c3 = c2;
		next_s1 = raw;
		next_s2 = s1;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			c1 <= 1'b0;
			c2 <= 1'b0;
			c3 <= 1'b0;
			s1 <= {SYNC_W{1'b1}};
			s2 <= {SYNC_W{1'b1}};
		end else begin
			c1 <= next_c1;
			c2 <= next_c2;
			c3 <= next_c3;
			s1 <= next_s1;
			s2 <= next_s2;
		end
	end

	// data is delayed as far as the clock, so it lines up with the edge
	assign pins.config_clock_pin_rise = c2 & ~c3;
	assign pins.data      = s2[7:0];
	assign pins.cs_n      = s2[8];
	assign pins.write_n   = s2[9];
	assign pins.program_n = s2[10];
	assign pins.mode      = s2[13:11];
	assign pins.gclk      = s2[17:14];
endmodule

// ---- rtl/fcpi_loader.sv ----
/*
 * configuration pin interface: memory clear, mode pick, serial or byte loading,
 * start-up, then hand-over of the shared pins to user logic.
 * assumes bidirectional pins are resolved outside from the _o/_oe pairs.
 */
module fcpi_loader
	import fcpi_pkg::*;
#(
	parameter int CONFIG_BYTES     = 16,
	parameter bit DONE_OPEN_DRAIN  = 1'b0,
	parameter bit RETAIN_BYTE_PORT = 1'b0
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	// configuration pins
	input  wire logic                  program_n,
	input  wire logic                  config_mode_sel_0,
	input  wire logic                  config_mode_sel_1,
	input  wire logic                  config_mode_sel_2,
	input  wire logic                  config_clock_pin_i,
	output logic                       config_clock_pin_o,
	output logic                       config_clock_pin_oe,
	input  wire logic [7:0]            config_byte_bits_i,
	output logic      [7:0]            config_byte_bits_o,
	output logic      [7:0]            config_byte_bits_oe,
	input  wire logic                  write_n,
	input  wire logic                  cs_n,
	output logic                       busy_dout_o,
	output logic                       busy_dout_oe,
	output logic                       init_o,
	output logic                       init_oe,
	output logic                       done_o,
	output logic                       done_oe,
	// global clock pins
	input  wire logic                  global_clock_in_0,
	input  wire logic                  global_clock_in_1,
	input  wire logic                  global_clock_in_2,
	input  wire logic                  global_clock_in_3,
	input  wire logic [3:0]            gclk_needed,
	output logic      [3:0]            gclk_buf_out,
	output logic      [3:0]            gclk_user_in,
	// user side of the shared pins
	input  wire logic [USER_PINS-1:0]  user_pin_o,
	input  wire logic [USER_PINS-1:0]  user_pin_oe,
	output logic      [USER_PINS-1:0]  user_pin_in,
	// configuration memory side
	output logic      [7:0]            cfg_byte,
	output logic                       cfg_byte_valid,
	output logic                       cfg_done
);
	import fcpi_pkg::*;

	fcpi_pin_if pins ();

	fcpi_pin_sync u_sync (
		.clk_sys (clk_sys),
		.reset   (reset),
		.config_clock_pin_in (config_clock_pin_i),
		.raw     ({global_clock_in_3, global_clock_in_2, global_clock_in_1, global_clock_in_0,
		            config_mode_sel_2, config_mode_sel_1, config_mode_sel_0,
		            program_n, write_n, cs_n, config_byte_bits_i}),
		.pins    (pins)
	);

	// ***************************************************
	// state
	// ***************************************************
	fcpi_state_t       state, next_state;
	logic [CNT_W-1:0]  count, next_count;
	logic [CNT_W-1:0]  nbytes, next_nbytes;
	logic [CNT_W-1:0]  busy_cnt, next_busy_cnt;
	logic [CNT_W-1:0]  div, next_div;
	logic [2:0]        mode, next_mode;
	logic [2:0]        nbits, next_nbits;
	logic [7:0]        shreg, next_shreg;
	logic              mclk, next_mclk;
	logic              next_config_clock_pin_o, next_config_clock_pin_oe, next_bd_o, next_bd_oe;
	logic              next_init_o, next_init_oe, next_done_o, next_done_oe;
	logic [7:0]        next_d_o, next_d_oe, next_cfg_byte;
	logic              next_cfg_valid, next_cfg_done;
	logic [3:0]        next_gbuf, next_guser;
	logic [USER_PINS-1:0] next_upin;
	logic              edge_seen, serial, mrise, accept;

	// master mode makes its own clock; otherwise the pin's synced edge counts
	always_comb begin
		serial    = (mode != MODE_BYTE_PARALLEL);
		mrise     = (div == CNT_W'(MCCLK_HALF - 1)) && !mclk;
		edge_seen = (mode == MODE_MASTER_SERIAL) ? mrise : pins.config_clock_pin_rise;
		accept    = (state == FCPI_LOAD) && edge_seen && (serial ||
		            (!pins.cs_n && !pins.write_n && busy_cnt == '0));
	end

	// next-state and pin values; pins default to released, the completion pin to driven low
	always_comb begin
		next_state     = state;
		next_count     = count;
		next_nbytes    = nbytes;
		next_busy_cnt  = (busy_cnt != '0) ? busy_cnt - CNT_W'(1) : busy_cnt;
		next_div       = '0;
		next_mclk      = 1'b0;
		next_mode      = mode;
		next_nbits     = nbits;
		next_shreg     = shreg;
		next_config_clock_pin_o    = 1'b0;
		next_config_clock_pin_oe   = 1'b0;
		next_bd_o      = 1'b0;
		next_bd_oe     = 1'b0;
		next_init_o    = 1'b0;
		next_init_oe   = 1'b0;
		next_done_o    = 1'b0;
		next_done_oe   = 1'b1;  // completion held low until start-up
		next_d_o       = 8'h00;
		next_d_oe      = 8'h00;  // data pins are inputs while loading
		next_cfg_byte  = cfg_byte;
		next_cfg_valid = 1'b0;
		next_cfg_done  = 1'b0;
		unique case (state)
			FCPI_CLEAR: begin
				next_init_oe = 1'b1;  // memory clear shown low
				next_count   = count + CNT_W'(1);
				if (pins.program_n && count >= CNT_W'(CLEAR_CYCLES - 1)) begin
					next_state = FCPI_MODE;
				end
			end
			FCPI_MODE: begin
				next_mode   = pins.mode;  // pins settled before this point
				next_nbytes = '0;
				next_nbits  = '0;
				next_state  = FCPI_LOAD;
			end
			FCPI_LOAD: begin
				if (mode == MODE_MASTER_SERIAL) begin
					// clock pin driven only in master mode
					next_div     = (div == CNT_W'(MCCLK_HALF - 1)) ? '0 : div + CNT_W'(1);
					next_mclk    = (div == CNT_W'(MCCLK_HALF - 1)) ? !mclk : mclk;
					next_config_clock_pin_o  = next_mclk;
					next_config_clock_pin_oe = 1'b1;
				end
				next_bd_oe = 1'b1;
				if (serial) begin
					next_bd_o = busy_dout_o;
					if (accept) begin
						next_bd_o  = pins.data[0];  // forward down the chain
						next_shreg = {shreg[6:0], pins.data[0]};
						next_nbits = nbits + 3'h1;
					end
				end else begin
					if (accept) begin
						next_shreg    = pins.data;
						next_busy_cnt = CNT_W'(BUSY_CYCLES);
					end
					next_bd_o = (next_busy_cnt != '0);  // pacing
				end
				if (accept && (!serial || nbits == 3'h7)) begin
					next_cfg_byte  = serial ? {shreg[6:0], pins.data[0]} : pins.data;
					next_cfg_valid = 1'b1;
					next_nbytes    = nbytes + CNT_W'(1);
					if (nbytes == CNT_W'(CONFIG_BYTES - 1)) begin
						next_state = FCPI_STARTUP;
						next_count = '0;
					end
				end
			end
			FCPI_STARTUP: begin
				next_done_o  = 1'b1;
				// last byte still gets its full busy time, last serial bit stays on the chain
				next_bd_oe   = 1'b1;
				next_bd_o    = serial ? busy_dout_o : (next_busy_cnt != '0);
				next_done_oe = !DONE_OPEN_DRAIN;
				next_count   = count + CNT_W'(1);
				if (count == CNT_W'(STARTUP_CYCLES - 1)) begin
					next_state = FCPI_USER;
				end
			end
			FCPI_USER: begin
				next_done_o   = 1'b1;
				next_done_oe  = !DONE_OPEN_DRAIN;
				next_cfg_done = 1'b1;
				next_init_o   = user_pin_o[0];
				next_init_oe  = user_pin_oe[0];
				if (serial || !RETAIN_BYTE_PORT) begin
					next_bd_o  = user_pin_o[1];
					next_bd_oe = user_pin_oe[1];
					next_d_o   = user_pin_o[9:2];
					next_d_oe  = user_pin_oe[9:2];
				end else begin
					next_bd_oe = 1'b1;  // kept byte port: busy stays dedicated, idle
				end
			end
		endcase
		// a low restart input overrides the state and the configuration pins, from any state
		if (!pins.program_n) begin
			next_state    = FCPI_CLEAR;
			next_count    = '0;
			next_busy_cnt = '0;
			next_cfg_done = 1'b0;
			// pins go to their clearing levels at once, not a cycle later
			next_cfg_valid = 1'b0;
			next_config_clock_pin_o    = 1'b0;
			next_config_clock_pin_oe   = 1'b0;
			next_bd_o      = 1'b0;
			next_bd_oe     = 1'b0;
			next_init_o    = 1'b0;
			next_init_oe   = 1'b1;
			next_done_o    = 1'b0;
			next_done_oe   = 1'b1;
			next_d_o       = 8'h00;
			next_d_oe      = 8'h00;
		end
		next_upin  = {pins.data, busy_dout_o, init_o};
		next_gbuf  = pins.gclk & gclk_needed;
		next_guser = pins.gclk & ~gclk_needed;
	end

	// registers only
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state               <= FCPI_CLEAR;
			count               <= '0;
			nbytes              <= '0;
			busy_cnt            <= '0;
			div                 <= '0;
			mclk                <= 1'b0;
			mode                <= MODE_SLAVE_SERIAL;
			nbits               <= 3'h0;
			shreg               <= BYTE_RESET;
			config_clock_pin_o  <= 1'b0;
			config_clock_pin_oe <= 1'b0;
			busy_dout_o         <= 1'b0;
			busy_dout_oe        <= 1'b0;
			init_o              <= 1'b0;
			init_oe             <= 1'b1;
			done_o              <= 1'b0;
			done_oe             <= 1'b1;
			config_byte_bits_o  <= 8'h00;
			config_byte_bits_oe <= 8'h00;
			cfg_byte            <= BYTE_RESET;
			cfg_byte_valid      <= 1'b0;
			cfg_done            <= 1'b0;
			gclk_buf_out        <= 4'h0;
			gclk_user_in        <= 4'h0;
			user_pin_in         <= '0;
		end else begin
			state               <= next_state;
			count               <= next_count;
			nbytes              <= next_nbytes;
			busy_cnt            <= next_busy_cnt;
			div                 <= next_div;
			mclk                <= next_mclk;
			mode                <= next_mode;
			nbits               <= next_nbits;
			shreg               <= next_shreg;
			config_clock_pin_o  <= next_config_clock_pin_o;
			config_clock_pin_oe <= next_config_clock_pin_oe;
			busy_dout_o         <= next_bd_o;
			busy_dout_oe        <= next_bd_oe;
			init_o              <= next_init_o;
			init_oe             <= next_init_oe;
			done_o              <= next_done_o;
			done_oe             <= next_done_oe;
			config_byte_bits_o  <= next_d_o;
			config_byte_bits_oe <= next_d_oe;
			cfg_byte            <= next_cfg_byte;
			cfg_byte_valid      <= next_cfg_valid;
			cfg_done            <= next_cfg_done;
			gclk_buf_out        <= next_gbuf;
			gclk_user_in        <= next_guser;
			user_pin_in         <= next_upin;
		end
	end
endmodule

// ---- testbench/fcpi_loader_sva.sv ----
/* checker of the fcpi_loader pins, bound to every fcpi_loader instance.
   assumes mode pins change only while the restart pin is low. */
module fcpi_loader_sva
	import fcpi_pkg::*;
(
	// clock and reset
	input wire logic	clk_sys,
	input wire logic	reset,
	// configuration pins
	input wire logic	program_n,
	input wire logic	config_mode_sel_0,
	input wire logic	config_mode_sel_1,
	input wire logic	config_mode_sel_2,
	input wire logic	config_clock_pin_oe,
	input wire logic [7:0]	config_byte_bits_oe,
	input wire logic	busy_dout_o,
	input wire logic	init_o,
	input wire logic	init_oe,
	input wire logic	done_o,
	input wire logic	done_oe,
	// user and memory side
	input wire logic [USER_PINS-1:0]	user_pin_oe,
	input wire logic	cfg_byte_valid,
	input wire logic	cfg_done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0]	mode;
	// one code for the three mode pins
	assign mode = {config_mode_sel_2, config_mode_sel_1, config_mode_sel_0};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	clk_dir_a:
	assert property (config_clock_pin_oe |-> mode == MODE_MASTER_SERIAL) else $error("clock pin driven off master");
	clk_user_a:
	assert property (cfg_done |-> !config_clock_pin_oe && !cfg_byte_valid) else $error("clock pin used after load");
	restart_a:
	assert property ($fell(program_n) |-> ##[1:4] (!cfg_done && !done_o && init_oe && !init_o))
		else $error("restart ignored");
	done_a:
	assert property (cfg_done |-> done_o && done_oe) else $error("completion pin not high");
	startup_a:
	assert property ($rose(done_o) |-> !cfg_done ##[1:9] cfg_done) else $error("start-up length wrong");
	clear_a:
	assert property ($fell(reset) |-> (init_oe && !init_o) [*8]) else $error("memory clear not shown");
	busy_a:
	assert property (cfg_byte_valid && mode == MODE_BYTE_PARALLEL |-> busy_dout_o [*2] ##1 !busy_dout_o)
		else $error("busy pacing wrong");
	user_a:
	assert property (cfg_done && $past(cfg_done) && $stable(user_pin_oe) |->
		config_byte_bits_oe == user_pin_oe[9:2] && init_oe == user_pin_oe[0]) else $error("pins not handed over");
	cover property (cfg_byte_valid && mode == MODE_BYTE_PARALLEL);
	cover property ($rose(cfg_done));
	cover property (config_clock_pin_oe);
endmodule
bind fcpi_loader fcpi_loader_sva u_fcpi_loader_sva (.clk_sys, .reset, .program_n, .config_mode_sel_0,
	.config_mode_sel_1, .config_mode_sel_2, .config_clock_pin_oe, .config_byte_bits_oe, .busy_dout_o,
	.init_o, .init_oe, .done_o, .done_oe, .user_pin_oe, .cfg_byte_valid, .cfg_done);

// ---- testbench/fcpi_host_model.sv ----
/* host model: byte and serial sender, serial memory for master mode.
   assumes its tasks are started just after a clk_sys edge. */
module fcpi_host_model (
	// timing and device feedback
	input wire logic	clk_sys,
	input wire logic	busy,
	input wire logic	config_clock_pin_line,
	input wire logic	master_on,
	// pins toward the device
	output logic	config_clock_pin,
	output logic [7:0]	data,
	output logic	cs_n,
	output logic	write_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0]	stream;
	// idle levels; the link clock stands still outside frames
	initial begin
		{config_clock_pin, cs_n, write_n, data, stream} = {3'h3, 40'h0};
	end
	// one 200 ns link period; data only moves while the clock is low
	task automatic pulse();
		repeat (4) @(posedge clk_sys);
		#2 config_clock_pin = 1'h1;
		repeat (4) @(posedge clk_sys);
		#2 config_clock_pin = 1'h0;
	endtask
	// byte write: hold it until busy has gone, then let go
	task automatic send_byte(input logic [7:0] b);
		{cs_n, write_n, data} = {2'h0, b};
		pulse();
		for (int n = 0; n < 40 && busy === 1'h1; n++) begin
			@(posedge clk_sys);
			#2;
		end
		{cs_n, write_n, data} = {2'h3, ~b}; // released data must not keep its value
		// let an edge pass so a following write never lowers the strobe in the same step
		@(posedge clk_sys);
		#2;
	endtask
	// one bit on the single data pin
	task automatic send_bit(input logic b);
		data[0] = b;
		pulse();
	endtask
	// memory shows its first bit before any clock arrives
	task automatic load_stream(input logic [31:0] s);
		{stream, data[0]} = {s, s[31]};
	endtask
	// next bit leaves on each falling edge of the driven clock
	always @(negedge config_clock_pin_line) begin
		if (master_on) begin
			{stream, data[0]} <= {stream << 1, stream[30]};
		end
	end
endmodule

// ---- testbench/tb_fcpi_loader.sv ----
/* bench of fcpi_loader: byte, slave and master loading, restart, clock pins.
   assumes fcpi_host_model plays the host on the configuration pins. */
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_fcpi_loader;
	timeunit 1ns;
	timeprecision 100ps;
	import fcpi_pkg::*;
	int	failures = 0;
	int	checked = 0;
	logic	clk_sys = 1'h0;
	logic	reset = 1'h1;
	logic	program_n = 1'h1;
	logic	config_mode_sel_0 = 1'h0;
	logic	config_mode_sel_1 = 1'h1;
	logic	config_mode_sel_2 = 1'h1;
	logic [3:0]	gpin = 4'h0;
	logic [3:0]	gclk_needed = 4'h0;
	logic [9:0]	user_pin_o = 10'h000;
	logic [9:0]	user_pin_oe = 10'h000;
	logic	host_config_clock_pin, cs_n, write_n, config_clock_pin_i, config_clock_pin_o, config_clock_pin_oe;
	logic	busy_dout_o, busy_dout_oe, init_o, init_oe, done_o, done_oe, cfg_byte_valid, cfg_done;
	logic [7:0]	host_data, config_byte_bits_i, config_byte_bits_o, config_byte_bits_oe, cfg_byte;
	logic [3:0]	gclk_buf_out, gclk_user_in;
	logic [9:0]	user_pin_in;
	logic [7:0]	got [$];
	always #12.5 clk_sys = ~clk_sys;
	// pin levels: the device wins where it drives, the host elsewhere
	assign config_clock_pin_i = config_clock_pin_oe ? config_clock_pin_o : host_config_clock_pin;
	assign config_byte_bits_i = (config_byte_bits_oe & config_byte_bits_o) | (~config_byte_bits_oe & host_data);
	// keep every accepted byte
	always @(posedge clk_sys) begin
		if (cfg_byte_valid === 1'h1) got.push_back(cfg_byte);
	end
	fcpi_loader #(.CONFIG_BYTES(2)) u_fcpi_loader (.clk_sys, .reset, .program_n, .config_mode_sel_0,
		.config_mode_sel_1, .config_mode_sel_2, .config_clock_pin_i, .config_clock_pin_o, .config_clock_pin_oe,
		.config_byte_bits_i, .config_byte_bits_o, .config_byte_bits_oe, .write_n, .cs_n, .busy_dout_o,
		.busy_dout_oe, .init_o, .init_oe, .done_o, .done_oe, .global_clock_in_0(gpin[0]),
		.global_clock_in_1(gpin[1]), .global_clock_in_2(gpin[2]), .global_clock_in_3(gpin[3]), .gclk_needed,
		.gclk_buf_out, .gclk_user_in, .user_pin_o, .user_pin_oe, .user_pin_in, .cfg_byte, .cfg_byte_valid, .cfg_done);
	fcpi_host_model u_fcpi_host_model (.clk_sys, .busy(busy_dout_o), .config_clock_pin_line(config_clock_pin_i),
		.master_on(config_clock_pin_oe), .config_clock_pin(host_config_clock_pin), .data(host_data), .cs_n, .write_n);
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task automatic wrap_up();
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// restart pin low, mode set meanwhile, then the clear runs out
	task automatic restart(input logic [2:0] m);
		program_n = 1'h0;
		cyc(6);
		config_mode_sel_2 = m[2];
		config_mode_sel_1 = m[1];
		config_mode_sel_0 = m[0];
		`CHK({init_oe, init_o, done_o, cfg_done}, 4'h8)
		program_n = 1'h1;
		cyc(CLEAR_CYCLES + 10);
	endtask
	task automatic wait_done();
		for (int n = 0; n < 400 && cfg_done !== 1'h1; n++) cyc(1);
		`CHK({cfg_done, done_o, done_oe}, 3'h7)
	endtask
	// a restart in mid-load drops the partial load; then pins go to the user
	task automatic t_byte();
		restart(MODE_BYTE_PARALLEL);
		u_fcpi_host_model.send_byte(8'h11);
		restart(MODE_BYTE_PARALLEL);
		got.delete();
		u_fcpi_host_model.send_byte(8'hA5);
		`CHK(config_clock_pin_oe, 1'h0)
		u_fcpi_host_model.send_byte(8'h3C);
		wait_done();
		`CHK({got[0], got[1]}, 16'hA53C)
		user_pin_o = 10'h2AA;
		user_pin_oe = 10'h3FF;
		cyc(4);
		`CHK({config_byte_bits_oe, config_byte_bits_o}, 16'hFFAA)
		`CHK({busy_dout_oe, busy_dout_o, init_oe, init_o}, 4'hE)
		`CHK(user_pin_in, 10'h2AA)
		user_pin_o = 10'h000;
		user_pin_oe = 10'h000;
		cyc(2);
		u_fcpi_host_model.send_byte(8'h77);
		`CHK(got.size(), 2)
	endtask
	// slave serial: MSB first, every bit seen again on the chain output
	task automatic t_serial();
		logic [15:0] w = 16'hC381;
		restart(MODE_SLAVE_SERIAL);
		got.delete();
		for (int i = 15; i >= 0; i--) begin
			u_fcpi_host_model.send_bit(w[i]);
			`CHK(busy_dout_o, w[i])
		end
		`CHK(config_clock_pin_oe, 1'h0)
		wait_done();
		`CHK({got[0], got[1]}, w)
	endtask
	// master serial: the device drives the clock and a memory answers
	task automatic t_master();
		u_fcpi_host_model.load_stream(32'h5A0F0000);
		got.delete();
		restart(MODE_MASTER_SERIAL);
		`CHK(config_clock_pin_oe, 1'h1)
		wait_done();
		`CHK({got[0], got[1]}, 16'h5A0F)
		`CHK(config_clock_pin_oe, 1'h0)
	endtask
	task automatic gck(input logic [3:0] need, input logic [3:0] pins, input logic [7:0] exp);
		gclk_needed = need;
		gpin = pins;
		cyc(5);
		`CHK({gclk_buf_out, gclk_user_in}, exp)
	endtask
	initial begin
		cyc(3);
		reset = 1'h0;
		t_byte();
		t_serial();
		t_master();
		gck(4'h5, 4'hF, 8'h5A);
		gck(4'hA, 4'h6, 8'h24);
		gck(4'hF, 4'h9, 8'h90);
		wrap_up();
	end
	// watchdog well beyond the expected run of about 600 cycles
	initial begin
		#100000;
		failures++;
		wrap_up();
	end
endmodule
